// ---- logic/cdrm_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module cdrm_ctrl import cdrm_pkg::*; #(
    parameter int MEAS_LOG2 = MEAS_BASE_LOG2
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Register port behind the management bus
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // Pins and analog status
    input  wire logic       rec_clk_pin,
    input  wire logic       reference_clock,
    input  wire logic       lock_lost_pin,
    input  wire logic       los_detect_pin,
    input  wire logic       rec_data_pin,
    input  wire logic       amp_data_pin,
    input  wire logic [7:0] vco_band_in,
    input  wire logic       coarse_lsb_in,
    input  wire logic       auto_acq_req,
    // Loop controls
    output logic            acq_start,
    output logic            lock_to_ref,
    output logic [1:0]      ref_range,
    output logic            holdover_en,
    output logic            limit_en,
    output logic [8:0]      upper_limit_code,
    output logic [8:0]      lower_limit_code,
    output logic            cdr_bypass,
    // Output buffers
    output logic            signal_absent,
    output logic            clk_out_pos,
    output logic            clk_out_neg,
    output logic            serial_data_out_pos,
    output logic            serial_data_out_neg
);
    // Reference edges per window; the first only opens it, so whole periods count
    function automatic logic [REFCNT_W-1:0] win_len(input logic [1:0] sel);
        win_len = (REFCNT_W'(1) << (MEAS_LOG2 + int'(sel))) + REFCNT_W'(1);
    endfunction : win_len

    // Register state
    logic [7:0] primary_ff, action_ff, polarity_ff, test_ff, format_ff;
    logic [7:0] opsel_ff, upper_ff, lower_ff, lsbs_ff, rdata_ff;
    logic [7:0] nxt_primary, nxt_action, nxt_polarity, nxt_test, nxt_format;
    logic [7:0] nxt_opsel, nxt_upper, nxt_lower, nxt_lsbs, nxt_rdata;
    logic       meas_go, acq_go, prbs_go;
    logic       done_ff;
    logic [RATE_W-1:0] result_ff;

    // Strobes fire when a host write clears a bit that was set; the bits never clear themselves
    always_comb begin
        nxt_primary  = primary_ff;
        nxt_action   = action_ff;
        nxt_polarity = polarity_ff;
        nxt_test     = test_ff;
        nxt_format   = format_ff;
        nxt_opsel    = opsel_ff;
        nxt_upper    = upper_ff;
        nxt_lower    = lower_ff;
        nxt_lsbs     = lsbs_ff;
        nxt_rdata    = rdata_ff;
        meas_go = reg_wr && reg_addr == ADDR_ACTION
                  && action_ff[ACT_MEAS_BIT] && !reg_wdata[ACT_MEAS_BIT];
        acq_go  = reg_wr && reg_addr == ADDR_ACTION
                  && action_ff[ACT_ACQ_BIT] && !reg_wdata[ACT_ACQ_BIT];
        prbs_go = reg_wr && reg_addr == ADDR_TEST
                  && test_ff[TST_GO_BIT] && !reg_wdata[TST_GO_BIT];
        if (reg_wr) begin
            unique case (reg_addr)
                ADDR_PRIMARY:  nxt_primary  = reg_wdata;
                ADDR_ACTION:   nxt_action   = reg_wdata;
                ADDR_POLARITY: nxt_polarity = reg_wdata;
                ADDR_TEST:     nxt_test     = reg_wdata;
                ADDR_FORMAT:   nxt_format   = reg_wdata;
                ADDR_OPSEL:    nxt_opsel    = reg_wdata;
                ADDR_UPPER:    nxt_upper    = reg_wdata;
                ADDR_LOWER:    nxt_lower    = reg_wdata;
                ADDR_LSBS:     nxt_lsbs     = reg_wdata;
                default:       nxt_rdata    = rdata_ff; // Read-only or unmapped
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_PRIMARY:  nxt_rdata = primary_ff;
                ADDR_ACTION:   nxt_rdata = action_ff;
                ADDR_POLARITY: nxt_rdata = polarity_ff;
                ADDR_TEST:     nxt_rdata = test_ff;
                ADDR_FORMAT:   nxt_rdata = format_ff;
                ADDR_OPSEL:    nxt_rdata = opsel_ff;
                ADDR_UPPER:    nxt_rdata = upper_ff;
                ADDR_LOWER:    nxt_rdata = lower_ff;
                ADDR_LSBS:     nxt_rdata = lsbs_ff;
                ADDR_STATUS:   nxt_rdata = {5'h0, done_ff, 1'b0, coarse_lsb_in};
                ADDR_VCO:      nxt_rdata = vco_band_in;
                ADDR_RATE_HI:  nxt_rdata = {1'b0, result_ff[22:16]};
                ADDR_RATE_MID: nxt_rdata = result_ff[15:8];
                ADDR_RATE_LO:  nxt_rdata = result_ff[7:0];
                default:       nxt_rdata = RST_REG;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            primary_ff  <= RST_REG;
            action_ff   <= RST_REG;
            polarity_ff <= RST_REG;
            test_ff     <= RST_REG;
            format_ff   <= RST_REG;
            opsel_ff    <= RST_REG;
            upper_ff    <= RST_REG;
            lower_ff    <= RST_REG;
            lsbs_ff     <= RST_REG;
            rdata_ff    <= RST_REG;
        end else begin
            primary_ff  <= nxt_primary;
            action_ff   <= nxt_action;
            polarity_ff <= nxt_polarity;
            test_ff     <= nxt_test;
            format_ff   <= nxt_format;
            opsel_ff    <= nxt_opsel;
            upper_ff    <= nxt_upper;
            lower_ff    <= nxt_lower;
            lsbs_ff     <= nxt_lsbs;
            rdata_ff    <= nxt_rdata;
        end
    end

    // Pin synchronisers; a level changes once stages two and three agree
    logic [SYNC_W-1:0] s1_ff, s2_ff, s3_ff, lvl_ff, nxt_lvl, rise;
    always_comb begin
        nxt_lvl = lvl_ff;
        for (int i = 0; i < SYNC_W; i++) begin
            if (s2_ff[i] == s3_ff[i]) begin
                nxt_lvl[i] = s3_ff[i];
            end
        end
        rise = nxt_lvl & ~lvl_ff;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_ff  <= '0;
            s2_ff  <= '0;
            s3_ff  <= '0;
            lvl_ff <= '0;
        end else begin
            s1_ff  <= {amp_data_pin, rec_data_pin, los_detect_pin,
                       lock_lost_pin, reference_clock, rec_clk_pin};
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            lvl_ff <= nxt_lvl;
        end
    end

    // Rate meter: count recovered edges across 2^(14+band) reference periods,
    // so the count is already the scaled ratio; it never steers the loop
    cdrm_meas_t        mstate_ff, nxt_mstate;
    logic [REFCNT_W-1:0] refcnt_ff, nxt_refcnt;
    logic [RATE_W-1:0] reccnt_ff, nxt_reccnt, nxt_result;
    logic              nxt_done;
    logic              fine_en;
    assign fine_en = primary_ff[PRI_FINE_BIT];
    always_comb begin
        nxt_mstate = mstate_ff;
        nxt_refcnt = refcnt_ff;
        nxt_reccnt = reccnt_ff;
        nxt_result = result_ff;
        nxt_done   = done_ff;
        if (meas_go && fine_en) begin
            nxt_mstate = MS_RUN;
            nxt_refcnt = '0;
            nxt_reccnt = '0;
            nxt_done   = 1'b0;
        end else begin
            unique case (mstate_ff)
                MS_IDLE: nxt_mstate = MS_IDLE;
                MS_RUN: begin
                    if (!fine_en) begin
                        nxt_mstate = MS_IDLE;                      // Abort, no valid result
                    end else if (refcnt_ff == win_len(primary_ff[7:6])) begin
                        nxt_result = reccnt_ff;
                        nxt_done   = 1'b1;
                        nxt_mstate = MS_IDLE;
                    end else begin
                        if (rise[SY_REF]) begin
                            nxt_refcnt = refcnt_ff + 1'b1;
                        end
                        if (rise[SY_REC] && refcnt_ff != '0 && !(&reccnt_ff)) begin // No wrap
                            nxt_reccnt = reccnt_ff + 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mstate_ff <= MS_IDLE;
            refcnt_ff <= '0;
            reccnt_ff <= '0;
            result_ff <= '0;
            done_ff   <= 1'b0;
        end else begin
            mstate_ff <= nxt_mstate;
            refcnt_ff <= nxt_refcnt;
            reccnt_ff <= nxt_reccnt;
            result_ff <= nxt_result;
            done_ff   <= nxt_done;
        end
    end

    // PRBS engine shared by generator and checker; one mode field selects
    logic gen_on, det_on, gen_run_ff, nxt_gen_run, prbs_bit, prbs_err;
    assign gen_on = format_ff[2:0] == FMT_PRBS && test_ff[2:0] == TF_GEN;
    assign det_on = format_ff[2:0] == FMT_PRBS && test_ff[2:0] == TF_DET;
    cdrm_prbs7 u_prbs (
        .clk     (clk),
        .sys_rst (sys_rst),
        .restart (prbs_go && gen_on),
        .step    (rise[SY_REC] && (det_on || gen_run_ff)),
        .check   (det_on),
        .din     (lvl_ff[SY_DAT]),
        .bit_out (prbs_bit),
        .err     (prbs_err)
    );

    // Output stage: clock divider, error stretcher and buffers
    logic       div2_ff, nxt_div2, acq_ff, nxt_acq, los_ff, nxt_los;
    logic       cp_ff, cn_ff, dp_ff, dn_ff, nxt_cp, nxt_dp, dbit;
    logic [1:0] errc_ff, nxt_errc;
    always_comb begin
        nxt_gen_run = (gen_run_ff || (prbs_go && gen_on)) && gen_on;
        nxt_div2    = rise[SY_REC] ? !div2_ff : div2_ff;
        nxt_errc    = errc_ff;
        if (prbs_err) begin
            nxt_errc = 2'h3;
        end else if (rise[SY_REC] && errc_ff != 2'h0) begin
            nxt_errc = errc_ff - 2'h1;
        end
        // Holdover blocks automatic requests, host strobe always acts
        nxt_acq = acq_go || (auto_acq_req && !opsel_ff[OPS_HOLD_BIT]);
        nxt_los = lvl_ff[SY_LOS] ^ polarity_ff[POL_LOS_BIT];
        nxt_cp  = (format_ff == FMT_DDR) ? div2_ff : lvl_ff[SY_REC];
        if (test_ff[TST_BYP_BIT]) begin
            dbit = lvl_ff[SY_AMP];
        end else if (gen_on) begin
            dbit = prbs_bit && gen_run_ff;
        end else if (det_on) begin
            dbit = errc_ff[0];                                     // High on counts 3 and 1
        end else begin
            dbit = lvl_ff[SY_DAT];
        end
        nxt_dp = dbit;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gen_run_ff <= 1'b0;
            div2_ff    <= 1'b0;
            errc_ff    <= 2'h0;
            acq_ff     <= 1'b0;
            los_ff     <= 1'b0;
            cp_ff      <= 1'b0;
            cn_ff      <= 1'b0;
            dp_ff      <= 1'b0;
            dn_ff      <= 1'b0;
        end else begin
            gen_run_ff <= nxt_gen_run;
            div2_ff    <= nxt_div2;
            errc_ff    <= nxt_errc;
            acq_ff     <= nxt_acq;
            los_ff     <= nxt_los;
            cp_ff      <= nxt_cp && !test_ff[TST_CLKD_BIT];
            cn_ff      <= !nxt_cp && !test_ff[TST_CLKD_BIT];
            dp_ff      <= nxt_dp && !test_ff[TST_DATD_BIT];
            dn_ff      <= !nxt_dp && !test_ff[TST_DATD_BIT];
        end
    end

    // Outputs straight from flops
    assign reg_rdata           = rdata_ff;
    assign acq_start           = acq_ff;
    assign lock_to_ref         = primary_ff[PRI_LTR_BIT];
    assign ref_range           = primary_ff[7:6];
    assign holdover_en         = opsel_ff[OPS_HOLD_BIT];
    assign limit_en            = opsel_ff[OPS_LIMIT_BIT];
    assign upper_limit_code    = {upper_ff, lsbs_ff[LSB_UPPER_BIT]};
    assign lower_limit_code    = {lower_ff, lsbs_ff[LSB_LOWER_BIT]};
    assign cdr_bypass          = test_ff[TST_BYP_BIT];
    assign signal_absent       = los_ff;
    assign clk_out_pos         = cp_ff;
    assign clk_out_neg         = cn_ff;
    assign serial_data_out_pos = dp_ff;
    assign serial_data_out_neg = dn_ff;

    AST_START_CLEARS: assert property (@(posedge clk) disable iff (sys_rst)
        meas_go && fine_en |=> !done_ff && mstate_ff == MS_RUN)
        else $error("start did not clear done");
    AST_DONE_HOLDS: assert property (@(posedge clk) disable iff (sys_rst)
        done_ff && !meas_go |=> done_ff && $stable(result_ff))
        else $error("result changed without start");
    AST_NO_FINE_IDLE: assert property (@(posedge clk) disable iff (sys_rst)
        !fine_en |=> mstate_ff == MS_IDLE)
        else $error("measured with fine mode off");
    AST_WINDOW_END: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(done_ff) |-> $past(refcnt_ff) == win_len($past(primary_ff[7:6])))
        else $error("window length wrong");
    AST_RATE_HIGH: assert property (@(posedge clk) disable iff (sys_rst)
        reg_rd && reg_addr == ADDR_RATE_HI |=> reg_rdata == {1'b0, $past(result_ff[22:16])})
        else $error("high result byte wrong");
    AST_ACQ_HOST: assert property (@(posedge clk) disable iff (sys_rst)
        acq_go |=> acq_start ##1 (lock_to_ref == $past(lock_to_ref)))
        else $error("host acquisition missed");
    AST_HOLD_NO_AUTO: assert property (@(posedge clk) disable iff (sys_rst)
        holdover_en && !acq_go |=> !acq_start)
        else $error("automatic acquisition in holdover");
    AST_LOS_POL: assert property (@(posedge clk) disable iff (sys_rst)
        ##1 signal_absent == ($past(lvl_ff[SY_LOS]) ^ $past(polarity_ff[POL_LOS_BIT])))
        else $error("signal absent polarity wrong");
    AST_DATA_OFF: assert property (@(posedge clk) disable iff (sys_rst)
        test_ff[TST_DATD_BIT] |=> !serial_data_out_pos && !serial_data_out_neg)
        else $error("data buffer not disabled");
    AST_PRBS_EXCL: assert property (@(posedge clk) disable iff (sys_rst)
        !(gen_on && det_on) and (det_on |=> !gen_run_ff))
        else $error("generator and detector together");
endmodule : cdrm_ctrl
`default_nettype wire

// ---- logic/cdrm_pkg.sv ----
`default_nettype none
package cdrm_pkg;
    // Register subaddresses
    localparam logic [3:0] ADDR_PRIMARY  = 4'h0;
    localparam logic [3:0] ADDR_ACTION   = 4'h1;
    localparam logic [3:0] ADDR_POLARITY = 4'h2;
    localparam logic [3:0] ADDR_TEST     = 4'h3;
    localparam logic [3:0] ADDR_FORMAT   = 4'h4;
    localparam logic [3:0] ADDR_OPSEL    = 4'h5;
    localparam logic [3:0] ADDR_UPPER    = 4'h6;
    localparam logic [3:0] ADDR_LOWER    = 4'h7;
    localparam logic [3:0] ADDR_LSBS     = 4'h8;
    localparam logic [3:0] ADDR_STATUS   = 4'h9;
    localparam logic [3:0] ADDR_VCO      = 4'hA;
    localparam logic [3:0] ADDR_RATE_HI  = 4'hB;
    localparam logic [3:0] ADDR_RATE_MID = 4'hC;
    localparam logic [3:0] ADDR_RATE_LO  = 4'hD;

    // Field positions
    localparam int PRI_LTR_BIT   = 0;
    localparam int PRI_FINE_BIT  = 1;
    localparam int PRI_RANGE_LSB = 6;
    localparam int ACT_MEAS_BIT  = 3;
    localparam int ACT_ACQ_BIT   = 5;
    localparam int POL_LOS_BIT   = 2;
    localparam int TST_GO_BIT    = 3;
    localparam int TST_CLKD_BIT  = 5;
    localparam int TST_DATD_BIT  = 6;
    localparam int TST_BYP_BIT   = 7;
    localparam int OPS_HOLD_BIT  = 1;
    localparam int OPS_LIMIT_BIT = 3;
    localparam int LSB_UPPER_BIT = 1;
    localparam int LSB_LOWER_BIT = 0;
    localparam int STS_CRS_BIT   = 0;
    localparam int STS_DONE_BIT  = 2;

    // Reset values and codes
    localparam logic [7:0] RST_REG  = 8'h00;
    localparam logic [7:0] FMT_DDR  = 8'h02;
    localparam logic [2:0] FMT_PRBS = 3'h5;
    localparam logic [2:0] TF_DET   = 3'h4;
    localparam logic [2:0] TF_GEN   = 3'h1;
    localparam logic [6:0] PRBS_SEED = 7'h7F;

    // Measurement sizes
    localparam int MEAS_BASE_LOG2 = 14;
    localparam int RATE_W         = 23;
    localparam int REFCNT_W       = 18;

    // Synchroniser lanes
    localparam int SY_REC = 0;
    localparam int SY_REF = 1;
    localparam int SY_LOL = 2;
    localparam int SY_LOS = 3;
    localparam int SY_DAT = 4;
    localparam int SY_AMP = 5;
    localparam int SYNC_W = 6;

    typedef enum {MS_IDLE, MS_RUN} cdrm_meas_t;
endpackage : cdrm_pkg
`default_nettype wire

// ---- logic/cdrm_prbs7.sv ----
`timescale 1ns/1ps
`default_nettype none
module cdrm_prbs7 import cdrm_pkg::*; (
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // Control
    input  wire logic restart,
    input  wire logic step,
    input  wire logic check,
    input  wire logic din,
    // Results
    output logic      bit_out,
    output logic      err
);
    logic [6:0] lfsr_ff;
    logic [6:0] nxt_lfsr;
    logic       err_ff;
    logic       nxt_err;
    logic       fb;

    // x^7 + x^6 + 1; checker self-seeds from the incoming stream
    always_comb begin
        fb       = lfsr_ff[6] ^ lfsr_ff[5];
        nxt_lfsr = lfsr_ff;
        nxt_err  = 1'b0;
        if (restart) begin
            nxt_lfsr = PRBS_SEED;
        end else if (step && check) begin
            nxt_err  = din ^ fb;
            nxt_lfsr = {lfsr_ff[5:0], din};
        end else if (step) begin
            nxt_lfsr = {lfsr_ff[5:0], fb};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lfsr_ff <= PRBS_SEED;
            err_ff  <= 1'b0;
        end else begin
            lfsr_ff <= nxt_lfsr;
            err_ff  <= nxt_err;
        end
    end

    assign bit_out = lfsr_ff[6];
    assign err     = err_ff;
endmodule : cdrm_prbs7
`default_nettype wire

// ---- test/cdrm_pins_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cdrm_pins_model #(
    parameter int REC_HALF = 40,
    parameter int REF_HALF = 120
) (
    // Level wanted on the amplified input, and an inversion of recovered data
    input  wire logic amp_level,
    input  wire logic data_flip,
    // Pins into the block
    output logic      rec_clk_pin,
    output logic      reference_clock,
    output logic      rec_data_pin,
    output logic      amp_data_pin
);
    logic [6:0] lfsr_ff = 7'h7F;
    // Recovered clock runs free, as the loop keeps oscillating
    initial begin
        rec_clk_pin = 1'b0;
        forever #(REC_HALF) rec_clk_pin = ~rec_clk_pin;
    end
    // Reference yardstick, offset so its edges never line up with clk
    initial begin
        reference_clock = 1'b0;
        #7;
        forever #(REF_HALF) reference_clock = ~reference_clock;
    end
    // Data steps the LFSR once per recovered bit so stale values never look right
    always @(posedge rec_clk_pin) lfsr_ff <= {lfsr_ff[5:0], lfsr_ff[6] ^ lfsr_ff[5]};
    assign rec_data_pin = lfsr_ff[0] ^ data_flip;
    assign amp_data_pin = amp_level;
endmodule : cdrm_pins_model
`default_nettype wire

// ---- test/test_cdrm_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_cdrm_ctrl import cdrm_pkg::*;;
    typedef struct {logic [7:0] val; int tol;} cdrm_exp_t;
    logic       clk, sys_rst, reg_wr, reg_rd, rd_tag, rd_seen, amp_level, data_flip, b;
    logic       los_detect_pin, coarse_lsb_in, auto_acq_req;
    logic       rec_clk_pin, reference_clock, rec_data_pin, amp_data_pin;
    logic       acq_start, lock_to_ref, holdover_en, limit_en, cdr_bypass, signal_absent;
    logic       clk_out_pos, clk_out_neg, serial_data_out_pos, serial_data_out_neg;
    logic [1:0] ref_range, rng, ls;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, vco_band_in, u, l;
    logic [8:0] upper_limit_code, lower_limit_code;
    logic [19:0] sh;
    cdrm_exp_t  exp_q[$];
    cdrm_exp_t  mon_e;
    int         failures, cmp_count, cycles, acq_cnt, seed, n;

    cdrm_ctrl #(.MEAS_LOG2(2)) u_cdrm_ctrl (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .rec_clk_pin(rec_clk_pin), .reference_clock(reference_clock),
        .lock_lost_pin(1'b0), .los_detect_pin(los_detect_pin),
        .rec_data_pin(rec_data_pin), .amp_data_pin(amp_data_pin), .vco_band_in(vco_band_in),
        .coarse_lsb_in(coarse_lsb_in), .auto_acq_req(auto_acq_req), .acq_start(acq_start),
        .lock_to_ref(lock_to_ref), .ref_range(ref_range), .holdover_en(holdover_en),
        .limit_en(limit_en), .upper_limit_code(upper_limit_code),
        .lower_limit_code(lower_limit_code), .cdr_bypass(cdr_bypass),
        .signal_absent(signal_absent), .clk_out_pos(clk_out_pos), .clk_out_neg(clk_out_neg),
        .serial_data_out_pos(serial_data_out_pos), .serial_data_out_neg(serial_data_out_neg));
    cdrm_pins_model u_cdrm_pins_model (.amp_level(amp_level), .data_flip(data_flip),
        .rec_clk_pin(rec_clk_pin), .reference_clock(reference_clock),
        .rec_data_pin(rec_data_pin), .amp_data_pin(amp_data_pin));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Hang guard, and pulse counter sampled away from the launching edge
    always @(negedge clk) begin
        cycles++;
        if (acq_start === 1'b1) acq_cnt++;
        if (cycles == 20000) begin
            failures++;
            $display("[ERR] %0t timeout", $time);
            finish_test();
        end
    end
    // Read answers land one cycle after the strobe; compare with the oldest note
    always @(posedge clk) rd_seen <= reg_rd & rd_tag;
    always @(negedge clk) begin
        if (rd_seen && exp_q.size() > 0) begin
            mon_e = exp_q.pop_front();
            cmp_count++;
            if ($isunknown(reg_rdata) || (int'(reg_rdata) - int'(mon_e.val)) > mon_e.tol ||
                (int'(mon_e.val) - int'(reg_rdata)) > mon_e.tol) begin
                failures++;
                $display("[ERR] %0t read got %h want %h", $time, reg_rdata, mon_e.val);
            end
        end
    end

    task automatic check(input logic [8:0] got, input logic [8:0] want);
        cmp_count++;
        if (got !== want) begin
            failures++;
            $display("[ERR] %0t pin got %h want %h", $time, got, want);
        end
    endtask : check
    // Twenty data output bits, one per recovered bit, newest in bit 0
    task automatic grab();
        sh = '0;
        repeat (20) begin
            @(posedge rec_clk_pin);
            sh = {sh[18:0], serial_data_out_pos};
        end
    endtask : grab
    // One idle cycle after each strobe keeps drivers from double assignment
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(negedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input bit push, input logic [7:0] v, input int tol);
        cdrm_exp_t e;
        @(negedge clk);
        e.val = v;
        e.tol = tol;
        if (push) exp_q.push_back(e);
        reg_rd <= 1'b1;
        rd_tag <= push;
        reg_addr <= a;
        @(negedge clk);
        reg_rd <= 1'b0;
    endtask : rd
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        {sys_rst, reg_wr, reg_rd, rd_tag, data_flip, amp_level} = 6'b100000;
        {los_detect_pin, auto_acq_req, reg_addr, reg_wdata} = '0;
        seed = 32'hf1d8;
        vco_band_in = 8'($random(seed));
        coarse_lsb_in = 1'($random(seed));
        repeat (5) @(negedge clk);
        sys_rst <= 1'b0;
        rd(ADDR_PRIMARY, 1, RST_REG, 0);
        rd(4'hE, 1, 8'h00, 0);
        rd(ADDR_VCO, 1, vco_band_in, 0);
        $display("registers test done");
        // Rate ratio 3 per reference period; the third run relies on the kept enable
        for (int i = 0; i < 3; i++) begin
            rng = (i == 0) ? 2'd0 : 2'd1;
            if (i < 2) wr(ADDR_PRIMARY, {rng, 6'h02});
            wr(ADDR_ACTION, 8'h08);
            wr(ADDR_ACTION, 8'h00);
            rd(ADDR_STATUS, 1, {7'h00, coarse_lsb_in}, 0);
            n = 0;
            do begin
                rd(ADDR_STATUS, 0, 8'h00, 0);
                n++;
            end while (reg_rdata[STS_DONE_BIT] !== 1'b1 && n < 400);
            rd(ADDR_STATUS, 1, {5'h00, 1'b1, 1'b0, coarse_lsb_in}, 0);
            check({7'h00, ref_range}, {7'h00, rng});
            rd(ADDR_RATE_HI, 1, 8'h00, 0);
            rd(ADDR_RATE_MID, 1, 8'h00, 0);
            rd(ADDR_RATE_LO, 1, 8'(12 << rng), 1);
            repeat (150) @(negedge clk);
            rd(ADDR_STATUS, 1, {5'h00, 1'b1, 1'b0, coarse_lsb_in}, 0);
            rd(ADDR_RATE_LO, 1, 8'(12 << rng), 1);
        end
        $display("measurement test done");
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_POLARITY, {5'h00, k[1], 2'b00});
            los_detect_pin <= k[0];
            repeat (10) @(negedge clk);
            check({8'h00, signal_absent}, {8'h00, k[0] ^ k[1]});
        end
        // Loop request under holdover must be swallowed; host strobe gives one pulse
        wr(ADDR_OPSEL, 8'h0A);
        n = acq_cnt;
        auto_acq_req <= 1'b1;
        @(negedge clk);
        auto_acq_req <= 1'b0;
        wr(ADDR_ACTION, 8'h20);
        wr(ADDR_ACTION, 8'h00);
        repeat (5) @(negedge clk);
        check(9'(acq_cnt - n), 9'd1);
        check({7'h00, holdover_en, limit_en}, 9'h003);
        u = 8'($random(seed));
        l = 8'($random(seed));
        ls = 2'($random(seed));
        wr(ADDR_UPPER, u);
        wr(ADDR_LOWER, l);
        wr(ADDR_LSBS, {6'h00, ls});
        repeat (3) @(negedge clk);
        check(upper_limit_code, {u, ls[LSB_UPPER_BIT]});
        check(lower_limit_code, {l, ls[LSB_LOWER_BIT]});
        $display("acquisition test done");
        for (int k = 0; k < 2; k++) begin
            amp_level <= k[0];
            wr(ADDR_TEST, 8'h80);
            repeat (10) @(negedge clk);
            check({7'h00, serial_data_out_pos, serial_data_out_neg}, {7'h00, k[0], ~k[0]});
        end
        // Clock output: 160 cycles hold 20 toggles divided, 40 undivided
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_FORMAT, k ? RST_REG : FMT_DDR);
            repeat (10) @(negedge clk);
            n = 0;
            b = clk_out_pos;
            repeat (160) begin
                @(negedge clk);
                n += int'(clk_out_pos !== b);
                b = clk_out_pos;
            end
            check(9'(n), k ? 9'd40 : 9'd20);
        end
        // Generator with inverted input, so passed-through data breaks the recurrence
        data_flip <= 1'b1;
        wr(ADDR_FORMAT, 8'h05);
        wr(ADDR_TEST, 8'h09);
        wr(ADDR_TEST, 8'h01);
        repeat (3) @(posedge rec_clk_pin);
        grab();
        check({8'h00, |(sh[12:0] ^ sh[18:6] ^ sh[19:7])}, 9'h000);
        check({8'h00, |sh}, 9'h001);
        data_flip <= 1'b0;
        // Detector: a clean stream stays quiet, one flipped bit gives pulses
        wr(ADDR_TEST, 8'h04);
        repeat (24) @(posedge rec_clk_pin);
        grab();
        check({8'h00, |sh}, 9'h000);
        @(negedge clk);
        data_flip <= 1'b1;
        repeat (8) @(negedge clk);
        data_flip <= 1'b0;
        grab();
        check({8'h00, $countones(sh) >= 2}, 9'h001);
        wr(ADDR_TEST, 8'hE0);
        repeat (8) @(negedge clk);
        for (int k = 0; k < 8; k++) begin
            @(negedge clk);
            check({5'h00, clk_out_pos, clk_out_neg, serial_data_out_pos, serial_data_out_neg},
                  9'h000);
        end
        $display("output test done");
        repeat (3) @(negedge clk);
        finish_test();
    end
endmodule : test_cdrm_ctrl
`default_nettype wire
